// ==== design/cafc_consts.svh ====
// Named offsets, field positions, reset values and bus codes of the filter control block.
`ifndef CAFC_CONSTS_SVH
`define CAFC_CONSTS_SVH

`define CAFC_BYTE_W        8
`define CAFC_FILT_PER_GRP  4
`define CAFC_MAX_FILT      16
`define CAFC_MAX_GRP       4
`define CAFC_ON_BIT        7
`define CAFC_MASK_HI       6
`define CAFC_MASK_LO       5
`define CAFC_FIFO_HI       4
`define CAFC_FIFO_LO       0
`define CAFC_FILT_RST      8'h00
`define CAFC_STAT_RST      16'h0000
`define CAFC_GRP_OFS_STEP  8'h04
`define CAFC_STAT_OFS      8'h10
`define CAFC_REGION_MASK   32'hFFFF_FF00
`define CAFC_OFS_HI        7
`define CAFC_ALIGN_MASK    8'hFC
`define CAFC_LANE_HI       1
`define CAFC_STAT_LANES    2
`define CAFC_SEL_NONE      4'hE
`define CAFC_SEL_STAT      4'hF
`define CAFC_HTRANS_ACT    1
`define CAFC_HSIZE_BYTE    3'h0
`define CAFC_HSIZE_HALF    3'h1
`define CAFC_HSIZE_WORD    3'h2
`define CAFC_HRESP_OKAY    1'h0
`define CAFC_BE_NONE       4'h0
`define CAFC_BE_ALL        4'hF
`define CAFC_BE_LO_HALF    4'h3
`define CAFC_BE_HI_HALF    4'hC
`define CAFC_BE_BYTE0      4'h1
`define CAFC_WORD_ZERO     32'h0000_0000

`endif

// ==== design/cafc_filter_slot.sv ====
// One filter's settings byte with the lock on mask and FIFO choice while the filter is on.
`timescale 1ns/1ns
`default_nettype none
`include "cafc_consts.svh"

module cafc_filter_slot
    import cafc_pkg::*;
(
    input  wire logic       clk_i,      // Block clock.
    input  wire logic       rst_n_i,    // Synchronous reset, active low.
    input  wire logic       wr_en_i,    // Write strobe for this filter's byte.
    input  wire logic [7:0] wr_byte_i,  // Byte written by software.
    output var  cafc_filt_t cfg_o,      // Current settings.
    output var  cafc_filt_t cfg_nxt_o,  // Settings after this cycle's write.
    output var  logic       lock_hit_o  // Write tried to change locked fields.
);

    cafc_filt_t st_r;
    cafc_filt_t st_nxt;
    logic       lock_hit;

    always_comb begin
        st_nxt   = st_r;
        lock_hit = 1'b0;
        if (wr_en_i) begin
            st_nxt.on = wr_byte_i[`CAFC_ON_BIT]; // R2
            if (!st_r.on) begin
                st_nxt.mask = wr_byte_i[`CAFC_MASK_HI:`CAFC_MASK_LO]; // R1
                st_nxt.fifo = wr_byte_i[`CAFC_FIFO_HI:`CAFC_FIFO_LO]; // R1
            end else if ((wr_byte_i[`CAFC_MASK_HI:`CAFC_MASK_LO] != st_r.mask) ||
                         (wr_byte_i[`CAFC_FIFO_HI:`CAFC_FIFO_LO] != st_r.fifo)) begin
                // Fields stay as they are; software must switch the filter off first.
                lock_hit = 1'b1; // R5
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r <= cafc_filt_t'(`CAFC_FILT_RST);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg_o      = st_r;
    assign cfg_nxt_o  = st_nxt;
    assign lock_hit_o = lock_hit;

endmodule
`default_nettype wire

// ==== design/cafc_pkg.sv ====
// Types shared by the filter control block and its slot and routing modules.
package cafc_pkg;

    typedef struct packed {
        logic       on;
        logic [1:0] mask;
        logic [4:0] fifo;
    } cafc_filt_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] sel;
        logic [3:0] be;
    } cafc_aphase_t;

    typedef struct packed {
        cafc_aphase_t ap;
        logic [31:0]  rdata;
        logic         ready;
        logic         resp;
        logic [15:0]  sticky;
    } cafc_top_st_t;

    typedef struct packed {
        logic       accept;
        logic [4:0] fifo;
        logic [1:0] mask;
        logic [3:0] filt;
    } cafc_route_t;

endpackage

// ==== design/cafc_route.sv ====
// Picks the accepting filter for a match strobe and reports its FIFO and mask choice.
`timescale 1ns/1ns
`default_nettype none
`include "cafc_consts.svh"

module cafc_route
    import cafc_pkg::*;
#(
    parameter int NF = 8
)
(
    input  wire logic                  clk_i,   // Block clock.
    input  wire logic                  rst_n_i, // Synchronous reset, active low.
    input  wire logic                  stb_i,   // Match result valid, one cycle.
    input  wire logic       [NF-1:0]   hit_i,   // Identifier matched filter i.
    input  wire cafc_filt_t [NF-1:0]   cfg_i,   // Filter settings.
    output var  cafc_route_t           route_o  // Registered routing decision.
);

    cafc_route_t st_r;
    cafc_route_t st_nxt;
    logic        found;

    // The winning filter index is four bits wide.
    if (NF < 1 || NF > `CAFC_MAX_FILT) begin : g_check
        $error("NF must lie between 1 and 16");
    end

    always_comb begin
        st_nxt        = st_r;
        st_nxt.accept = 1'b0;
        found         = 1'b0;
        if (stb_i) begin
            // The lowest numbered enabled filter that matched takes the message.
            for (int i = 0; i < NF; i++) begin
                if (!found && hit_i[i] && cfg_i[i].on) begin // R6
                    found         = 1'b1;
                    st_nxt.accept = 1'b1;
                    st_nxt.fifo   = cfg_i[i].fifo; // R4
                    st_nxt.mask   = cfg_i[i].mask; // R3
                    st_nxt.filt   = 4'(i);
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign route_o = st_r;

endmodule
`default_nettype wire

// ==== design/cafc_top.sv ====
// AHB-Lite register bank for receive acceptance filters with routing of matches to FIFOs.
//
// Notes on behaviour
// R1: Each byte holds on bit, mask, FIFO.
// R2: On bit set enables, clear disables filter.
// R3: Two-bit mask choice selects mask zero-three.
// R4: Matching message goes to chosen FIFO index.
// R5: Mask and FIFO change only while off.
// R6: Disabled filter never accepts or routes messages.
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "cafc_consts.svh"

module cafc_top
    import cafc_pkg::*;
#(
    parameter int          N_GROUPS  = 2,
    parameter logic [31:0] BASE_ADDR = 32'h0000_0000
)
(
    input  wire logic                              REF_CLK_I,      // Block clock, 100 MHz.
    input  wire logic                              RST_N_I,        // Sync reset, active low.
    input  wire logic                              HSEL_I,         // AHB slave select.
    input  wire logic [31:0]                       HADDR_I,        // AHB address.
    input  wire logic [1:0]                        HTRANS_I,       // AHB transfer type.
    input  wire logic                              HWRITE_I,       // AHB write.
    input  wire logic [2:0]                        HSIZE_I,        // AHB transfer size.
    input  wire logic [31:0]                       HWDATA_I,       // AHB write data.
    input  wire logic                              HREADY_I,       // AHB bus ready.
    output var  logic [31:0]                       HRDATA_O,       // AHB read data.
    output var  logic                              HREADYOUT_O,    // AHB slave ready.
    output var  logic                              HRESP_O,        // AHB response.
    input  wire logic                              MATCH_STB_I,    // Match result valid.
    input  wire logic [N_GROUPS*4-1:0]             MATCH_HIT_I,    // Per-filter identifier hit.
    output var  cafc_filt_t [N_GROUPS*4-1:0]       FILT_CFG_O,     // Settings per filter.
    output var  logic                              ROUTE_ACCEPT_O, // Message accepted, pulse.
    output var  logic [4:0]                        ROUTE_FIFO_O,   // Destination FIFO.
    output var  logic [1:0]                        ROUTE_MASK_O,   // Mask of winning filter.
    output var  logic [3:0]                        ROUTE_FILT_O    // Winning filter index.
);

    localparam int NF = N_GROUPS * `CAFC_FILT_PER_GRP;

    localparam cafc_top_st_t ST_RST = '{
        ap:     '0,
        rdata:  `CAFC_WORD_ZERO,
        ready:  1'b1,
        resp:   `CAFC_HRESP_OKAY,
        sticky: `CAFC_STAT_RST
    };

    if (N_GROUPS < 1 || N_GROUPS > `CAFC_MAX_GRP) begin : g_check
        $error("N_GROUPS must lie between 1 and 4");
    end

    // Byte lanes touched by a transfer of the given size at the given low address bits.
    function automatic logic [3:0] cafc_byte_en(input logic [2:0] size,
                                                input logic [1:0] lo);
        logic [3:0] be;
        be = `CAFC_BE_NONE;
        case (size)
            `CAFC_HSIZE_BYTE: begin
                be = 4'(`CAFC_BE_BYTE0 << lo);
            end
            `CAFC_HSIZE_HALF: begin
                be = lo[1] ? `CAFC_BE_HI_HALF : `CAFC_BE_LO_HALF;
            end
            `CAFC_HSIZE_WORD: begin
                be = `CAFC_BE_ALL;
            end
            default: begin
                be = `CAFC_BE_NONE;
            end
        endcase
        return be;
    endfunction

    // Register selected by an address: a group index, the status word, or nothing.
    function automatic logic [3:0] cafc_decode(input logic [31:0] addr);
        logic [3:0] sel;
        logic [7:0] ofs;
        sel = `CAFC_SEL_NONE;
        ofs = addr[`CAFC_OFS_HI:0] & `CAFC_ALIGN_MASK;
        if ((addr & `CAFC_REGION_MASK) == (BASE_ADDR & `CAFC_REGION_MASK)) begin
            if (ofs == `CAFC_STAT_OFS) begin
                sel = `CAFC_SEL_STAT;
            end
            for (int g = 0; g < N_GROUPS; g++) begin
                if (ofs == 8'(g * `CAFC_GRP_OFS_STEP)) begin
                    sel = 4'(g);
                end
            end
        end
        return sel;
    endfunction

    cafc_top_st_t              st_r;
    cafc_top_st_t              st_nxt;
    logic        [NF-1:0]      slot_we;
    logic        [NF-1:0][7:0] slot_wb;
    logic        [NF-1:0]      slot_lock;
    cafc_filt_t  [NF-1:0]      slot_cfg;
    cafc_filt_t  [NF-1:0]      slot_cfg_nxt;
    cafc_route_t               route;
    logic        [3:0]         rd_sel;
    logic        [15:0]        clr_bits;
    logic        [15:0]        set_bits;
    logic        [31:0]        rd_word;

    for (genvar i = 0; i < NF; i++) begin : g_slot
        cafc_filter_slot u_slot (
            .clk_i      (REF_CLK_I),
            .rst_n_i    (RST_N_I),
            .wr_en_i    (slot_we[i]),
            .wr_byte_i  (slot_wb[i]),
            .cfg_o      (slot_cfg[i]),
            .cfg_nxt_o  (slot_cfg_nxt[i]),
            .lock_hit_o (slot_lock[i])
        );
    end

    cafc_route #(
        .NF (NF)
    ) u_route (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .stb_i   (MATCH_STB_I),
        .hit_i   (MATCH_HIT_I),
        .cfg_i   (slot_cfg),
        .route_o (route)
    );

    always_comb begin
        st_nxt   = st_r;
        clr_bits = '0;
        set_bits = '0;
        rd_sel   = `CAFC_SEL_NONE;
        rd_word  = `CAFC_WORD_ZERO;

        // Data phase of the write taken last cycle; each filter owns one byte lane.
        for (int i = 0; i < NF; i++) begin
            slot_we[i] = st_r.ap.wr &&
                         (st_r.ap.sel == 4'(i / `CAFC_FILT_PER_GRP)) &&
                         st_r.ap.be[i % `CAFC_FILT_PER_GRP]; // R1
            slot_wb[i] = HWDATA_I[(i % `CAFC_FILT_PER_GRP) * `CAFC_BYTE_W +: `CAFC_BYTE_W];
            set_bits[i] = slot_lock[i]; // R5
        end

        // Lock violations are sticky; write one to clear, a new violation wins.
        if (st_r.ap.wr && st_r.ap.sel == `CAFC_SEL_STAT) begin
            for (int k = 0; k < `CAFC_STAT_LANES; k++) begin
                if (st_r.ap.be[k]) begin
                    clr_bits[k * `CAFC_BYTE_W +: `CAFC_BYTE_W] =
                        HWDATA_I[k * `CAFC_BYTE_W +: `CAFC_BYTE_W];
                end
            end
        end
        st_nxt.sticky = (st_r.sticky & ~clr_bits) | set_bits;

        // Address phase; the slave never stalls, so every phase completes at once.
        st_nxt.ap    = '0;
        st_nxt.ready = 1'b1;
        st_nxt.resp  = `CAFC_HRESP_OKAY;
        if (HSEL_I && HREADY_I && HTRANS_I[`CAFC_HTRANS_ACT]) begin
            st_nxt.ap.sel = cafc_decode(HADDR_I);
            st_nxt.ap.be  = cafc_byte_en(HSIZE_I, HADDR_I[`CAFC_LANE_HI:0]);
            st_nxt.ap.wr  = HWRITE_I;
            st_nxt.ap.rd  = !HWRITE_I;
            rd_sel        = HWRITE_I ? `CAFC_SEL_NONE : st_nxt.ap.sel;
        end

        // Reads see the effect of a write whose data phase overlaps them.
        if (rd_sel == `CAFC_SEL_STAT) begin
            rd_word[NF-1:0] = st_nxt.sticky[NF-1:0];
        end else if (rd_sel != `CAFC_SEL_NONE) begin
            for (int i = 0; i < NF; i++) begin
                if (rd_sel == 4'(i / `CAFC_FILT_PER_GRP)) begin
                    rd_word[(i % `CAFC_FILT_PER_GRP) * `CAFC_BYTE_W +: `CAFC_BYTE_W] =
                        slot_cfg_nxt[i];
                end
            end
        end
        st_nxt.rdata = rd_word;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign HRDATA_O       = st_r.rdata;
    assign HREADYOUT_O    = st_r.ready;
    assign HRESP_O        = st_r.resp;
    assign FILT_CFG_O     = slot_cfg; // R3
    assign ROUTE_ACCEPT_O = route.accept; // R6
    assign ROUTE_FIFO_O   = route.fifo; // R4
    assign ROUTE_MASK_O   = route.mask;
    assign ROUTE_FILT_O   = route.filt;

endmodule
`default_nettype wire

// ==== sim/cafc_match_model.sv ====
// Behavioural model of the receive matching logic that raises match strobes.
`timescale 1ns/1ns
`default_nettype none
module cafc_match_model #(
    parameter int NF = 8
)
(
    input  wire logic          clk_i, // Block clock.
    output var  logic          stb_o, // Match strobe.
    output var  logic [NF-1:0] hit_o  // Per-filter hits.
);
    initial begin
        stb_o = 1'b0;
        hit_o = '0;
    end

    task automatic send(input logic [NF-1:0] h, input int gap);
        repeat (gap) @(posedge clk_i);
        stb_o <= 1'b1;
        hit_o <= h;
        @(posedge clk_i);
        stb_o <= 1'b0;
        // Hits are meaningless outside a strobe, so they carry the inverse as junk.
        hit_o <= ~h;
    endtask
endmodule
`default_nettype wire

// ==== sim/cafc_top_assertions.sv ====
// Checker bound to the filter control block: bus read data, lock and routing checks.
`timescale 1ns/1ns
`default_nettype none
module cafc_top_assertions
    import cafc_pkg::*;
#(
    parameter int N_GROUPS = 2
)
(
    input wire logic                        REF_CLK_I,      // Clock.
    input wire logic                        RST_N_I,        // Reset, active low.
    input wire logic                        HSEL_I,         // Select.
    input wire logic [1:0]                  HTRANS_I,       // Transfer type.
    input wire logic                        HWRITE_I,       // Write.
    input wire logic                        HREADY_I,       // Bus ready.
    input wire logic [31:0]                 HRDATA_O,       // Read data.
    input wire logic                        MATCH_STB_I,    // Match strobe.
    input wire logic [N_GROUPS*4-1:0]       MATCH_HIT_I,    // Match hits.
    input wire cafc_filt_t [N_GROUPS*4-1:0] FILT_CFG_O,     // Filter settings.
    input wire logic                        ROUTE_ACCEPT_O, // Accept pulse.
    input wire logic [4:0]                  ROUTE_FIFO_O,   // Destination FIFO.
    input wire logic [1:0]                  ROUTE_MASK_O,   // Mask choice.
    input wire logic [3:0]                  ROUTE_FILT_O    // Winning filter.
);
    localparam int NF = N_GROUPS * 4;
    cafc_filt_t [NF-1:0] prev_cfg_r;
    logic [NF-1:0]       prev_hit_r;
    logic [NF-1:0]       on_vec;
    logic [NF-1:0]       prev_on;
    logic                prev_rd_r;
    logic                lock_ok;

    always_ff @(posedge REF_CLK_I) begin
        prev_cfg_r <= FILT_CFG_O;
        prev_hit_r <= MATCH_HIT_I;
        prev_rd_r  <= HSEL_I & HREADY_I & HTRANS_I[1] & ~HWRITE_I;
    end

    always_comb begin
        lock_ok = 1'b1;
        for (int i = 0; i < NF; i++) begin
            on_vec[i]  = FILT_CFG_O[i].on;
            prev_on[i] = prev_cfg_r[i].on;
            if (prev_cfg_r[i].on && FILT_CFG_O[i][6:0] != prev_cfg_r[i][6:0]) begin
                lock_ok = 1'b0;
            end
        end
    end

    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    chk_rdata_idle: assert property (!prev_rd_r |-> HRDATA_O == 32'h0000_0000)
        else $error("read data outside a read data phase");
    chk_accept_on: assert property (
        ROUTE_ACCEPT_O |-> prev_on[ROUTE_FILT_O] && prev_hit_r[ROUTE_FILT_O])
        else $error("accepted filter was off or not hit");
    chk_accept_cause: assert property (
        MATCH_STB_I && |(MATCH_HIT_I & on_vec) |=> ROUTE_ACCEPT_O)
        else $error("enabled hit gave no accept");
    chk_no_accept: assert property (
        !(MATCH_STB_I && |(MATCH_HIT_I & on_vec)) |=> !ROUTE_ACCEPT_O)
        else $error("accept without enabled hit");
    chk_route_fifo: assert property (
        ROUTE_ACCEPT_O |-> ROUTE_FIFO_O == prev_cfg_r[ROUTE_FILT_O].fifo)
        else $error("routed FIFO differs from filter choice");
    chk_route_mask: assert property (
        ROUTE_ACCEPT_O |-> ROUTE_MASK_O == prev_cfg_r[ROUTE_FILT_O].mask)
        else $error("routed mask differs from filter choice");
    chk_lowest_win: assert property (
        ROUTE_ACCEPT_O |->
        ((prev_hit_r & prev_on) & ((NF'(1) << ROUTE_FILT_O) - NF'(1))) == '0)
        else $error("a lower enabled filter was passed over");
    chk_lock_fields: assert property (lock_ok)
        else $error("mask or FIFO choice changed while filter on");

    cov_accept: cover property (ROUTE_ACCEPT_O);
    cov_locked_on: cover property (|prev_on && HSEL_I && HWRITE_I);
    cov_read: cover property (prev_rd_r);
endmodule

bind cafc_top cafc_top_assertions #(.N_GROUPS(N_GROUPS)) chk_u (.REF_CLK_I, .RST_N_I, .HSEL_I,
    .HTRANS_I, .HWRITE_I, .HREADY_I, .HRDATA_O, .MATCH_STB_I, .MATCH_HIT_I, .FILT_CFG_O,
    .ROUTE_ACCEPT_O, .ROUTE_FIFO_O, .ROUTE_MASK_O, .ROUTE_FILT_O);
`default_nettype wire

// ==== sim/cafc_top_test.sv ====
// Self-checking testbench for the filter control block.
`timescale 1ns/1ns
`default_nettype none
module cafc_top_test
    import cafc_pkg::*;
;
    logic             ref_clk, rst_n, hsel, hwrite, hready, hresp, stb, acc;
    logic [1:0]       htrans, rmask;
    logic [2:0]       hsize;
    logic [31:0]      haddr, hwdata, hrdata, q;
    logic [7:0]       hit;
    logic [4:0]       rfifo;
    logic [3:0]       rfilt;
    cafc_filt_t [7:0] cfg;
    int               fail_count = 0;
    int               tests_run = 0;
    int               cyc = 0;

    cafc_top dut_u (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .MATCH_STB_I(stb), .MATCH_HIT_I(hit), .FILT_CFG_O(cfg), .ROUTE_ACCEPT_O(acc),
        .ROUTE_FIFO_O(rfifo), .ROUTE_MASK_O(rmask), .ROUTE_FILT_O(rfilt));
    cafc_match_model #(.NF(8)) pm_u (.clk_i(ref_clk), .stb_o(stb), .hit_o(hit));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, e);
        chk(hresp, 1'b0);
    endtask

    task automatic route(input logic [7:0] h, input int gap, input logic [11:0] e);
        pm_u.send(h, gap);
        @(posedge ref_clk);
        chk({acc, rfifo, rmask, rfilt}, e);
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fail_count++;
            end_sim;
        end
    end

    initial begin
        rst_n  = 1'b0;
        hsel   = 1'b0;
        htrans = 2'b00;
        haddr  = 32'h0000_0000;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        chk(cfg, 64'h0);
        rd(32'h0, 32'h0000_0000);
        wr(32'h0, 32'h45E0_BF00);
        rd(32'h0, 32'h45E0_BF00);
        wr(32'h4, 32'h8AC3_5401);
        rd(32'h4, 32'h8AC3_5401);
        chk(cfg, 64'h8AC3_5401_45E0_BF00);
        route(8'h09, 0, 12'h000);
        route(8'h0F, 3, {1'b1, 5'h1F, 2'h1, 4'h1});
        route(8'hF0, 0, {1'b1, 5'h03, 2'h2, 4'h6});
        route(8'h80, 0, {1'b1, 5'h0A, 2'h0, 4'h7});
        wr(32'h0, 32'h1FE0_8000);
        rd(32'h0, 32'h1FE0_BF00);
        rd(32'h10, 32'h0000_0002);
        wr(32'h10, 32'h0000_0002);
        rd(32'h10, 32'h0000_0000);
        wr(32'h0, 32'h1FE0_0000);
        rd(32'h0, 32'h1FE0_3F00);
        route(8'h02, 0, {1'b0, 5'h0A, 2'h0, 4'h7});
        wr(32'h0, 32'h1FE0_0000);
        rd(32'h0, 32'h1FE0_0000);
        route(8'h0C, 0, {1'b1, 5'h00, 2'h3, 4'h2});
        wr(32'h8, 32'hFFFF_FFFF);
        rd(32'h8, 32'h0000_0000);
        rd(32'h104, 32'h0000_0000);
        // A reset in mid-run clears settings, routing and the sticky lock status.
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        chk(cfg, 64'h0);
        chk({acc, rfifo, rmask, rfilt}, 12'h000);
        rd(32'h10, 32'h0000_0000);
        rd(32'h0, 32'h0000_0000);
        end_sim;
    end
endmodule
`default_nettype wire
